// ### flash_self_program_sequencer_tb.sv
// Purpose: self-checking bench for the flash self-program sequencer
// Assumes: short program time of 20 cycles, 32-word pages
// Notes: rows cover arm and store cases, hand tests cover buffer, lock, reset
`timescale 1ns/10ps
`include "fsps_defines.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module flash_self_program_sequencer_tb;
  typedef struct {logic [7:0] cmd; logic [15:0] ptr; logic [3:0] dly; logic er; logic wr; logic halt;} fsps_row_t;
  localparam logic [15:0] PMASK = 16'h003f;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, store_strobe, eeprom_write, cpu_halt, section_read_block, ready_irq;
  logic flash_erase, flash_write, store_go = 1'b0, ee_go = 1'b0;
  logic [3:0] store_delay = 4'h0, boot_lock_bits;
  logic [15:0] flash_page_addr;
  logic [1:0] op;
  int mismatches = 0, check_count = 0, cyc = 0, n;
  fsps_row_t r;
  fsps_row_t rows [8] = '{
    '{8'h03, 16'h017f, 4'h0, 1'b1, 1'b0, 1'b0},
    '{8'h03, 16'h1900, 4'h0, 1'b1, 1'b0, 1'b1},
    '{8'h05, 16'h1900, 4'h1, 1'b0, 1'b1, 1'b1},
    '{8'h05, 16'h0140, 4'h1, 1'b0, 1'b1, 1'b0},
    '{8'h03, 16'h0140, 4'h9, 1'b0, 1'b0, 1'b0},
    '{8'h05, 16'h0140, 4'h9, 1'b0, 1'b0, 1'b0},
    '{8'h07, 16'h0140, 4'h0, 1'b0, 1'b0, 1'b0},
    '{8'h02, 16'h0140, 4'h0, 1'b0, 1'b0, 1'b0}};
  always #50 clk = ~clk;
  fsps_top #(.PROG_CYCLES(20)) fsps_top_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .store_strobe(store_strobe), .eeprom_write(eeprom_write), .cpu_halt(cpu_halt),
    .section_read_block(section_read_block), .ready_irq(ready_irq), .flash_erase(flash_erase),
    .flash_write(flash_write), .flash_page_addr(flash_page_addr), .boot_lock_bits(boot_lock_bits));
  fsps_cpu_model fsps_cpu_model_i (.clk(clk), .rst_b(rst_b), .store_go(store_go), .store_delay(store_delay),
    .ee_go(ee_go), .store_strobe(store_strobe), .eeprom_write(eeprom_write));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // this wait ends once pready is seen high; the bench timeout ends it on a hang
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // store request goes out at the arming edge so the window timing is fixed
  task automatic arm(input logic [7:0] cmd, input logic [3:0] d);
    apb(1'b1, `FSPS_ADDR_CTRL, {24'h0, cmd});
    store_go <= 1'b1; store_delay <= d;
    @(posedge clk);
    store_go <= 1'b0;
  endtask
  task automatic wait_idle();
    while ((flash_erase | flash_write) === 1'b1) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin mismatches++; end_sim(); end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    `CHK("lock reset", 4'hf, boot_lock_bits)
    apb(1'b0, `FSPS_ADDR_CTRL, 32'h0);
    `CHK("ctrl reset", 8'h00, rd[7:0])
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      apb(1'b1, `FSPS_ADDR_PTR, {16'h0, r.ptr});
      arm(r.cmd, r.dly);
      n = 0; op = 2'b00;
      while (op == 2'b00 && n < 8) begin @(posedge clk); n++; op = {flash_erase, flash_write}; end
      `CHK("erase", r.er, op[1])
      `CHK("write", r.wr, op[0])
      if (op != 2'b00) begin
        `CHK("halt", r.halt, cpu_halt)
        `CHK("page", r.ptr & ~PMASK, flash_page_addr)
        apb(1'b1, `FSPS_ADDR_PTR, 32'h0);
        `CHK("latched", r.ptr & ~PMASK, flash_page_addr)
        apb(1'b0, `FSPS_ADDR_CTRL, 32'h0);
        `CHK("held", r.cmd[4:0], rd[4:0])
        `CHK("busy", 1'b1, rd[`FSPS_BIT_BUSY])
        apb(1'b1, `FSPS_ADDR_CTRL, {27'h0, `FSPS_CMD_REEN});
        wait_idle();
        apb(1'b0, `FSPS_ADDR_CTRL, 32'h0);
        `CHK("busy kept", 1'b1, rd[`FSPS_BIT_BUSY])
        `CHK("blocked", 1'b1, section_read_block)
        arm({3'h0, `FSPS_CMD_REEN}, 4'h0);
        repeat (4) @(posedge clk);
      end else repeat (8) @(posedge clk);
      apb(1'b0, `FSPS_ADDR_CTRL, 32'h0);
      `CHK("busy end", 1'b0, rd[`FSPS_BIT_BUSY])
      `CHK("auto clear", 5'h00, rd[4:0])
    end
    // interrupt level is high once the enable bit clears, with interrupt enable set
    arm(8'h81, 4'h9);
    @(posedge clk);
    `CHK("irq armed", 1'b0, ready_irq)
    repeat (8) @(posedge clk);
    `CHK("irq idle", 1'b1, ready_irq)
    // busy left set by an erase, then cleared by a buffer load
    apb(1'b1, `FSPS_ADDR_PTR, 32'h0140);
    arm(8'h03, 4'h0);
    repeat (3) @(posedge clk);
    wait_idle();
    apb(1'b1, `FSPS_ADDR_PTR, 32'h0007);
    apb(1'b1, `FSPS_ADDR_DATA, 32'h1234);
    arm(8'h01, 4'h0);
    repeat (3) @(posedge clk);
    apb(1'b0, `FSPS_ADDR_CTRL, 32'h0);
    `CHK("load busy", 1'b0, rd[`FSPS_BIT_BUSY])
    apb(1'b0, `FSPS_ADDR_STAT, 32'h0);
    `CHK("word3", 32'h8, rd)
    apb(1'b0, `FSPS_ADDR_BUF, 32'h0);
    `CHK("buf data", 32'h1234, rd)
    @(posedge clk) ee_go <= 1'b1;
    @(posedge clk) ee_go <= 1'b0;
    apb(1'b0, `FSPS_ADDR_STAT, 32'h0);
    `CHK("ee discard", 32'h0, rd)
    apb(1'b0, `FSPS_ADDR_BUF, 32'h0);
    `CHK("ee blank", {16'h0, `FSPS_BUF_BLANK}, rd)
    arm(8'h01, 4'h0);
    apb(1'b1, `FSPS_ADDR_CTRL, 32'h10);
    apb(1'b0, `FSPS_ADDR_STAT, 32'h0);
    `CHK("reen discard", 32'h0, rd)
    apb(1'b1, `FSPS_ADDR_PTR, 32'h0004);
    // late cpu store, so the store register carries this load on the last window cycle
    arm(8'h01, 4'h9);
    apb(1'b1, `FSPS_ADDR_STORE, 32'h0);
    apb(1'b0, `FSPS_ADDR_STAT, 32'h0);
    `CHK("word2", 32'h4, rd)
    apb(1'b1, `FSPS_ADDR_PTR, 32'h0140);
    arm(8'h05, 4'h0);
    repeat (3) @(posedge clk);
    wait_idle();
    apb(1'b0, `FSPS_ADDR_STAT, 32'h0);
    `CHK("write clears buf", 32'h0, rd)
    arm({3'h0, `FSPS_CMD_REEN}, 4'h0);
    // lock bits: data bits 5..2 low program, pointer is junk on purpose
    apb(1'b1, `FSPS_ADDR_DATA, 32'hd7);
    apb(1'b1, `FSPS_ADDR_PTR, 32'hffff);
    arm(8'h09, 4'h0);
    n = 0;
    do begin
      apb(1'b0, `FSPS_ADDR_CTRL, 32'h0);
      `CHK("lock readable", 2'b00, {cpu_halt, section_read_block})
      n++;
    end while (rd[`FSPS_BIT_LOCK] === 1'b1 && n < 20);
    `CHK("lock clear", 1'b0, rd[`FSPS_BIT_LOCK])
    `CHK("lock bits", 4'h5, boot_lock_bits)
    apb(1'b1, `FSPS_ADDR_LOCK, 32'h0);
    apb(1'b0, `FSPS_ADDR_LOCK, 32'h0);
    `CHK("lock ro", 4'h5, rd[3:0])
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 1'b1, er)
    // reset in mid-run empties the buffer
    arm(8'h01, 4'h0);
    @(posedge clk) rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `FSPS_ADDR_STAT, 32'h0);
    `CHK("reset buf", 32'h0, rd)
    end_sim();
  end
endmodule

// ### fsps_cpu_model.sv
// Purpose: cpu-side partner issuing store instructions and eeprom writes
// Assumes: requests from the bench arrive one cycle wide
// Notes: store lands 1 + delay cycles after the request is seen
`timescale 1ns/10ps
module fsps_cpu_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic store_go,
  input wire logic [3:0] store_delay,
  input wire logic ee_go,
  output logic store_strobe,
  output logic eeprom_write
);
  logic [3:0] cnt_reg;
  logic act_reg;
  logic fire;
  // a late store is legal cpu behaviour; the device must then ignore it
  assign fire = (store_go && store_delay == 4'h0) || (act_reg && cnt_reg == 4'h1);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      act_reg <= 1'b0;
      cnt_reg <= 4'h0;
      store_strobe <= 1'b0;
      eeprom_write <= 1'b0;
    end else begin
      store_strobe <= fire;
      eeprom_write <= ee_go;
      if (store_go) begin
        act_reg <= (store_delay != 4'h0);
        cnt_reg <= store_delay;
      end else if (act_reg) begin
        act_reg <= (cnt_reg > 4'h1);
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule

// ### fsps_defines.svh
// Purpose: constants for the flash self-program sequencer
// Assumes: 10 MHz clock, apb byte addressing
// Notes: rule summary follows
// Operation
// - page write bit with enable writes buffer on store within four cycles
// - erase and write take page from upper pointer bits, ignore data pair
// - page write bit clears on completion or four-cycle timeout
// - page write to halting section stops cpu; other section write keeps it readable
// - page erase bit with enable erases page on store within four cycles
// - page erase bit clears on completion or four-cycle timeout
// - erase of halting section stops cpu; other section erase keeps it readable
// - enable permits store only four cycles; otherwise store does nothing
// - enable alone loads data pair into buffer word, pointer bit zero ignored
// - enable clears after store or timeout; held during erase and write
// - only five low-bit encodings accepted, others have no effect
// - target address latched at start; pointer may change afterwards
// - lock bit programming ignores the address pointer
// - erase uses only page index bits of pointer
// - buffer cleared after page write, on re-enable write, on reset
// - eeprom write during buffer loading discards loaded data
// - ready irq asserted while enabled and enable bit clear
// - erase or write blocks section reads; busy flag held until re-enable
// - lock set programs boot lock bits whose data bits 5..2 are zero
// - lock programming keeps whole flash readable
// - re-enable with enable clears busy on store; refused while busy
// - re-enable write during loading aborts load and discards data
// - busy flag cleared when a buffer load starts
// - lock set bit clears on completion or four-cycle timeout
`ifndef FSPS_DEFINES_SVH
`define FSPS_DEFINES_SVH
`define FSPS_ADDR_CTRL 12'h000
`define FSPS_ADDR_PTR 12'h004
`define FSPS_ADDR_DATA 12'h008
`define FSPS_ADDR_LOCK 12'h00c
`define FSPS_ADDR_STORE 12'h010
`define FSPS_ADDR_STAT 12'h014
`define FSPS_ADDR_BUF 12'h018
`define FSPS_BUF_BLANK 16'hffff
`define FSPS_BIT_IE 7
`define FSPS_BIT_BUSY 6
`define FSPS_BIT_REEN 4
`define FSPS_BIT_LOCK 3
`define FSPS_BIT_PGWR 2
`define FSPS_BIT_PGER 1
`define FSPS_BIT_EN 0
`define FSPS_CMD_REEN 5'h11
`define FSPS_CMD_LOCK 5'h09
`define FSPS_CMD_PGWR 5'h05
`define FSPS_CMD_PGER 5'h03
`define FSPS_CMD_LOAD 5'h01
`define FSPS_ARM_CYCLES 3'h4
`define FSPS_PROG_TIME_US 3700
`define FSPS_CLK_MHZ 10
`define FSPS_PROG_CYCLES (`FSPS_PROG_TIME_US * `FSPS_CLK_MHZ)
`define FSPS_LOCK_RESET 4'hf
`endif

// ### fsps_pkg.sv
// Purpose: types for the flash self-program sequencer
// Assumes: nothing
// Notes: none
package fsps_pkg;
  typedef enum logic [2:0] {
    FSPS_IDLE,
    FSPS_ARMED,
    FSPS_ERASE,
    FSPS_WRITE,
    FSPS_LOCKP
  } fsps_state_t;
endpackage

// ### fsps_top.sv
// Purpose: flash self-program sequencer with apb register access
// Assumes: store instruction arrives as a write to the store register or store_strobe
// Notes: flash array is outside; this block drives its erase/write strobes
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "fsps_defines.svh"
module fsps_top #(
  parameter int PAGE_WORDS = 32,
  parameter int PTR_W = 16,
  parameter int HALT_PAGE_START = 96,
  parameter int PROG_CYCLES = `FSPS_PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic store_strobe,
  input wire logic eeprom_write,
  output logic cpu_halt,
  output logic section_read_block,
  output logic ready_irq,
  output logic flash_erase,
  output logic flash_write,
  output logic [PTR_W-1:0] flash_page_addr,
  output logic [3:0] boot_lock_bits
);
  localparam int WORD_W = $clog2(PAGE_WORDS);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  if (PAGE_WORDS < 2 || (PAGE_WORDS & (PAGE_WORDS - 1)) != 0 || WORD_W + 1 >= PTR_W) begin : page_size_check
    $error("fsps_top: page size must be a power of two fitting the pointer");
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctrl_reg;
  logic [PTR_W-1:0] ptr_reg;
  logic [15:0] data_reg;
  logic [3:0] lock_reg;
  logic [PTR_W-1:0] page_reg;
  logic [2:0] arm_reg;
  logic [CNT_W-1:0] busy_cnt_reg;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] buf_valid_reg;
  logic loading_reg;
  fsps_pkg::fsps_state_t state_reg;
  fsps_pkg::fsps_state_t state_next;

  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && !pwrite && apb_setup;
  wire wr_ctrl = apb_wr && paddr == `FSPS_ADDR_CTRL;
  wire wr_ptr = apb_wr && paddr == `FSPS_ADDR_PTR;
  wire wr_data = apb_wr && paddr == `FSPS_ADDR_DATA;
  wire wr_store = apb_wr && paddr == `FSPS_ADDR_STORE;
  wire mapped = paddr == `FSPS_ADDR_CTRL || paddr == `FSPS_ADDR_PTR || paddr == `FSPS_ADDR_DATA
                || paddr == `FSPS_ADDR_LOCK || paddr == `FSPS_ADDR_STORE || paddr == `FSPS_ADDR_STAT
                || paddr == `FSPS_ADDR_BUF;
  wire store = store_strobe || wr_store;

  wire busy_op = state_reg == fsps_pkg::FSPS_ERASE || state_reg == fsps_pkg::FSPS_WRITE;
  wire [4:0] cmd_low = pwdata[4:0];
  wire cmd_legal = cmd_low == `FSPS_CMD_REEN || cmd_low == `FSPS_CMD_LOCK || cmd_low == `FSPS_CMD_PGWR
                   || cmd_low == `FSPS_CMD_PGER || cmd_low == `FSPS_CMD_LOAD;
  wire armed = state_reg == fsps_pkg::FSPS_ARMED;
  wire fire = armed && store && !eeprom_write;
  // refused while busy
  // a control write that meets a store in one cycle is dropped, so the fired command stays intact
  wire arm_ok = wr_ctrl && cmd_legal && state_reg != fsps_pkg::FSPS_LOCKP && !busy_op && !fire;
  wire timeout = armed && arm_reg == 3'h1 && !fire;
  wire [4:0] armed_cmd = ctrl_reg[4:0];
  wire [PTR_W-1:0] page_of_ptr = {ptr_reg[PTR_W-1:WORD_W+1], {(WORD_W + 1){1'b0}}};
  wire [WORD_W-1:0] word_sel = ptr_reg[WORD_W:1];
  wire [PTR_W-1:0] halt_base = PTR_W'(HALT_PAGE_START * PAGE_WORDS * 2);
  wire target_halt = page_reg >= halt_base;
  wire op_done = busy_cnt_reg == CNT_W'(1);
  wire is_load_fire = fire && armed_cmd == `FSPS_CMD_LOAD;
  wire is_reen_fire = fire && armed_cmd == `FSPS_CMD_REEN;
  wire buf_clear = (state_reg == fsps_pkg::FSPS_WRITE && op_done)
                   || (wr_ctrl && pwdata[`FSPS_BIT_REEN]) || (eeprom_write && loading_reg);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      fsps_pkg::FSPS_IDLE: begin
        if (arm_ok) begin
          state_next = fsps_pkg::FSPS_ARMED;
        end
      end
      fsps_pkg::FSPS_ARMED: begin
        if (fire && armed_cmd == `FSPS_CMD_PGER) begin
          state_next = fsps_pkg::FSPS_ERASE;
        end else if (fire && armed_cmd == `FSPS_CMD_PGWR) begin
          state_next = fsps_pkg::FSPS_WRITE;
        end else if (fire && armed_cmd == `FSPS_CMD_LOCK) begin
          state_next = fsps_pkg::FSPS_LOCKP;
        end else if (fire || (timeout && !arm_ok)) begin
          state_next = fsps_pkg::FSPS_IDLE;
        end
      end
      fsps_pkg::FSPS_ERASE, fsps_pkg::FSPS_WRITE, fsps_pkg::FSPS_LOCKP: begin
        if (op_done) begin
          state_next = fsps_pkg::FSPS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= fsps_pkg::FSPS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arm_reg <= 3'h0;
    end else if (arm_ok) begin
      arm_reg <= `FSPS_ARM_CYCLES;
    end else if (armed && arm_reg != 3'h0) begin
      arm_reg <= arm_reg - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_cnt_reg <= '0;
    end else if (fire && armed_cmd inside {`FSPS_CMD_PGER, `FSPS_CMD_PGWR, `FSPS_CMD_LOCK}) begin
      busy_cnt_reg <= CNT_W'(PROG_CYCLES);
    end else if (busy_cnt_reg != '0) begin
      busy_cnt_reg <= busy_cnt_reg - CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control/status byte
  logic busy_flag_reg;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= 8'h00;
    end else if (arm_ok) begin
      ctrl_reg <= {pwdata[`FSPS_BIT_IE], 2'b00, pwdata[4:0]};
    end else begin
      if (wr_ctrl) begin
        ctrl_reg[`FSPS_BIT_IE] <= pwdata[`FSPS_BIT_IE];
      end
      // auto-clear on completion or timeout
      // a refused control write in the same cycle must not swallow the clear
      if (timeout || (fire && state_next == fsps_pkg::FSPS_IDLE) || op_done) begin
        ctrl_reg[4:0] <= 5'h00;
      end
    end
  end

  // busy until re-enable; cleared on load
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_flag_reg <= 1'b0;
    end else if (fire && (armed_cmd == `FSPS_CMD_PGER || armed_cmd == `FSPS_CMD_PGWR)) begin
      busy_flag_reg <= 1'b1;
    end else if (is_reen_fire || is_load_fire) begin
      busy_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_reg <= '0;
      data_reg <= 16'h0000;
    end else begin
      if (wr_ptr) begin
        ptr_reg <= pwdata[PTR_W-1:0];
      end
      if (wr_data) begin
        data_reg <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      page_reg <= '0;
    end else if (fire && (armed_cmd == `FSPS_CMD_PGER || armed_cmd == `FSPS_CMD_PGWR)) begin
      page_reg <= page_of_ptr;
    end
  end

  // zero data bits program lock bits
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lock_reg <= `FSPS_LOCK_RESET;
    end else if (fire && armed_cmd == `FSPS_CMD_LOCK) begin
      lock_reg <= lock_reg & data_reg[5:2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // temporary page buffer
  always_ff @(posedge clk) begin
    if (is_load_fire) begin
      buf_mem[word_sel] <= data_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      buf_valid_reg <= '0;
      loading_reg <= 1'b0;
    end else if (buf_clear) begin
      buf_valid_reg <= '0;
      loading_reg <= 1'b0;
    end else if (is_load_fire) begin
      buf_valid_reg[word_sel] <= 1'b1;
      loading_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  wire [7:0] ctrl_view = {ctrl_reg[`FSPS_BIT_IE], busy_flag_reg, 1'b0, ctrl_reg[4:0]};
  // unloaded words read as blank flash
  wire [15:0] buf_word = buf_valid_reg[word_sel] ? buf_mem[word_sel] : `FSPS_BUF_BLANK;
  wire [31:0] rd_mux = paddr == `FSPS_ADDR_CTRL ? {24'h0, ctrl_view}
                     : paddr == `FSPS_ADDR_PTR ? 32'(ptr_reg)
                     : paddr == `FSPS_ADDR_DATA ? {16'h0, data_reg}
                     : paddr == `FSPS_ADDR_LOCK ? {28'h0, lock_reg}
                     : paddr == `FSPS_ADDR_STAT ? 32'(buf_valid_reg)
                     : paddr == `FSPS_ADDR_BUF ? {16'h0, buf_word}
                     : 32'h0;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cpu_halt <= 1'b0;
      section_read_block <= 1'b0;
      ready_irq <= 1'b0;
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_page_addr <= '0;
      boot_lock_bits <= `FSPS_LOCK_RESET;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !mapped;
      if (apb_rd) begin
        prdata <= rd_mux;
      end
      // halt only for the halting section; lock keeps flash readable
      // halt spans the same cycles as the erase or write strobe
      cpu_halt <= busy_op && target_halt;
      section_read_block <= busy_flag_reg;
      ready_irq <= ctrl_view[`FSPS_BIT_IE] && !ctrl_view[`FSPS_BIT_EN];
      flash_erase <= state_reg == fsps_pkg::FSPS_ERASE;
      flash_write <= state_reg == fsps_pkg::FSPS_WRITE;
      flash_page_addr <= page_reg;
      boot_lock_bits <= lock_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  window_timeout_a: assert property (@(posedge clk) disable iff (!rst_b)
    arm_ok && !store ##1 (!store && !eeprom_write) [*4] |=> state_reg == fsps_pkg::FSPS_IDLE)
    else $error("arm window did not expire");
  illegal_cmd_a: assert property (@(posedge clk) disable iff (!rst_b)
    wr_ctrl && !cmd_legal && state_reg == fsps_pkg::FSPS_IDLE |=> state_reg == fsps_pkg::FSPS_IDLE)
    else $error("illegal command armed");
  en_held_a: assert property (@(posedge clk) disable iff (!rst_b)
    busy_op |-> ctrl_reg[`FSPS_BIT_EN])
    else $error("enable dropped during operation");
  busy_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    fire && armed_cmd == `FSPS_CMD_PGWR |=> busy_flag_reg ##1 section_read_block)
    else $error("busy not raised on write");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl_reg[`FSPS_BIT_IE] && !ctrl_reg[`FSPS_BIT_EN] |=> ready_irq)
    else $error("ready irq missing");
  page_latch_a: assert property (@(posedge clk) disable iff (!rst_b)
    busy_op && $stable(state_reg) |-> $stable(page_reg))
    else $error("target page moved during operation");
  buf_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == fsps_pkg::FSPS_WRITE && op_done |=> buf_valid_reg == '0)
    else $error("buffer not cleared after write");
  load_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
    is_load_fire |=> !busy_flag_reg)
    else $error("busy not cleared by load");
  lock_no_halt_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == fsps_pkg::FSPS_LOCKP |=> !cpu_halt)
    else $error("halt during lock programming");
  eeprom_discard_a: assert property (@(posedge clk) disable iff (!rst_b)
    eeprom_write && loading_reg |=> buf_valid_reg == '0)
    else $error("eeprom write kept buffer");
endmodule
